// ==== hdl/ccu_channel.sv ====
// one capture/compare register with its pin logic
`timescale 1ns/1ps
module ccu_channel (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire ccu_pkg::ccu_chan_cfg_type cfg_i,
  input wire logic dbl_lead_i,
  input wire logic dbl_follow_i,
  input wire logic partner_match_i,
  // allocated time base
  input wire ccu_pkg::ccu_tmr_type tmr_i,
  // register write
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  // pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  // state
  output logic [15:0] val_o,
  output logic irq_o,
  output logic match_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic rise;
  logic fall;
  logic trig;
  logic is_cmp;
  logic once;
  logic done_r;
  logic first;
  logic cap;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

  always_comb begin
    case (cfg_i.edge_sel)
      ccu_pkg::CCU_EDGE_RISE: trig = rise;
      ccu_pkg::CCU_EDGE_FALL: trig = fall;
      default: trig = rise | fall;
    endcase
  end

  assign cap = trig && cfg_i.mode == ccu_pkg::CCU_CAPTURE;
  assign is_cmp = cfg_i.mode inside {ccu_pkg::CCU_CMP0, ccu_pkg::CCU_CMP1,
    ccu_pkg::CCU_CMP2, ccu_pkg::CCU_CMP3};
  assign match_o = is_cmp && tmr_i.upd && tmr_i.cnt == val_o;
  assign once = cfg_i.mode inside {ccu_pkg::CCU_CMP2, ccu_pkg::CCU_CMP3};
  assign first = match_o && !(once && done_r && !tmr_i.ovf);

  // a match in the overflow cycle belongs to the new period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
    end else if (ce_i) begin
      if (match_o) begin
        done_r <= 1'b1;
      end else if (tmr_i.ovf) begin
        done_r <= 1'b0;
      end
    end
  end

  // capture beats a software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      val_o <= ccu_pkg::TMR_RST;
    end else if (ce_i) begin
      if (cap) begin
        val_o <= tmr_i.cnt;
      end else if (wr_en_i) begin
        val_o <= wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= cap || first;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
    end else if (ce_i) begin
      if (dbl_lead_i && (match_o || partner_match_i)) begin
        pin_o <= ~pin_o;
      end else if (dbl_follow_i) begin
        pin_o <= pin_o;
      end else if (cfg_i.mode == ccu_pkg::CCU_CMP1 && match_o) begin
        pin_o <= ~pin_o;
      end else if (cfg_i.mode == ccu_pkg::CCU_CMP3 && first) begin
        pin_o <= 1'b1;
      end else if (cfg_i.mode == ccu_pkg::CCU_CMP3 && tmr_i.ovf) begin
        pin_o <= 1'b0;
      end
    end
  end

  // pin is an output in modes 1 and 3 or as a double-mode leader, never as a follower
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      pin_oe_o <= !dbl_follow_i && (dbl_lead_i
        || cfg_i.mode == ccu_pkg::CCU_CMP1
        || cfg_i.mode == ccu_pkg::CCU_CMP3);
    end
  end

  sequence s_capture;
    ce_i && cap;
  endsequence

  AST_CAPTURE_VALUE: assert property (@(posedge clk_i)
    disable iff (rst_i) s_capture |=> val_o == $past(tmr_i.cnt) && irq_o)
    else $error("capture did not store timer or raise request");

  AST_SINGLE_PER_PERIOD: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && once && match_o && done_r && !tmr_i.ovf
    |=> !irq_o)
    else $error("second request in one period");

  AST_PERIOD_FIRST: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && once && match_o && tmr_i.ovf |=> irq_o)
    else $error("first match of a new period gave no request");

  AST_MODE3_LOW: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && cfg_i.mode == ccu_pkg::CCU_CMP3
      && !dbl_lead_i && !dbl_follow_i && tmr_i.ovf && !first |=> !pin_o)
    else $error("mode 3 pin not cleared on overflow");

  AST_TOGGLE: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && cfg_i.mode == ccu_pkg::CCU_CMP1 && match_o
      && !dbl_follow_i && !dbl_lead_i |=> pin_o != $past(pin_o))
    else $error("mode 1 match did not toggle pin");

  AST_RISE_ONCE: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && rise ##1 ce_i |-> !rise)
    else $error("edge seen twice");

endmodule : ccu_channel

// ==== hdl/ccu_pkg.sv ====
// shared constants and types of the dual capture/compare array
package ccu_pkg;

  localparam int TMR_W = 16;
  localparam int N_UNIT = 2;
  localparam int N_CH = 16;
  localparam int TIS_W = 3;
  localparam int PRE_W = 10;
  localparam int PRE_BASE = 3;
  localparam logic [15:0] TMR_MAX = 16'hFFFF;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [9:0] PRE_RST = 10'h000;
  localparam logic [9:0] PRE_ONES = 10'h3FF;

  typedef enum logic [2:0] {
    CCU_OFF,
    CCU_CAPTURE,
    CCU_CMP0,
    CCU_CMP1,
    CCU_CMP2,
    CCU_CMP3
  } ccu_mode_type;

  // code 3 is taken as both edges
  typedef enum logic [1:0] {
    CCU_EDGE_RISE,
    CCU_EDGE_FALL,
    CCU_EDGE_BOTH
  } ccu_edge_type;

  typedef enum logic [1:0] {
    CCU_SRC_PRESCALE,
    CCU_SRC_EXT_PIN,
    CCU_SRC_GPT_OVF
  } ccu_src_type;

  typedef struct packed {
    ccu_mode_type mode;
    ccu_edge_type edge_sel;
    logic alloc;
  } ccu_chan_cfg_type;

  typedef struct packed {
    logic run;
    ccu_src_type src;
    logic [2:0] tis;
    logic [15:0] reload;
  } ccu_tmr_cfg_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic upd;
    logic ovf;
  } ccu_tmr_type;

endpackage : ccu_pkg

// ==== hdl/ccu_timebase.sv ====
// one reloadable 16-bit time base with prescaler and input select
`timescale 1ns/1ps
module ccu_timebase #(
  parameter bit HAS_EXT = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire ccu_pkg::ccu_tmr_cfg_type cfg_i,
  // tick sources
  input wire logic ext_pin_i,
  input wire logic gpt_ovf_i,
  // state
  output ccu_pkg::ccu_tmr_type tmr_o,
  output logic irq_o
);

  logic [ccu_pkg::PRE_W-1:0] pre_r;
  logic [ccu_pkg::PRE_W-1:0] pre_term;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_rise;
  logic tick;
  logic wrap;

  // divider 8 << tis
  assign pre_term = ccu_pkg::PRE_ONES >>
    (ccu_pkg::PRE_W - ccu_pkg::PRE_BASE - int'(cfg_i.tis));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r <= ccu_pkg::PRE_RST;
    end else if (ce_i) begin
      // a shorter divider chosen mid-count restarts instead of wrapping
      if (!cfg_i.run || pre_r >= pre_term) begin
        pre_r <= ccu_pkg::PRE_RST;
      end else begin
        pre_r <= pre_r + 1'b1;
      end
    end
  end

  // external count pin: synchronise, then count rising edges once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else if (ce_i) begin
      ext_s1_r <= ext_pin_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_s3_r;

  always_comb begin
    tick = 1'b0;
    case (cfg_i.src)
      ccu_pkg::CCU_SRC_PRESCALE: tick = pre_r == pre_term;
      ccu_pkg::CCU_SRC_EXT_PIN: tick = HAS_EXT && ext_rise;
      ccu_pkg::CCU_SRC_GPT_OVF: tick = gpt_ovf_i;
      default: tick = 1'b0;
    endcase
    tick = tick & cfg_i.run;
  end
  assign wrap = tmr_o.cnt == ccu_pkg::TMR_MAX;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_o.cnt <= ccu_pkg::TMR_RST;
      tmr_o.upd <= 1'b0;
      tmr_o.ovf <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      tmr_o.upd <= tick;
      tmr_o.ovf <= tick & wrap;
      irq_o <= tick & wrap;
      if (tick) begin
        tmr_o.cnt <= wrap ? cfg_i.reload : tmr_o.cnt + 1'b1;
      end
    end
  end

  sequence s_wrap_tick;
    ce_i && tick && wrap;
  endsequence

  AST_RELOAD_ON_WRAP: assert property (@(posedge clk_i)
    disable iff (rst_i) s_wrap_tick
    |=> tmr_o.cnt == $past(cfg_i.reload) && tmr_o.ovf && irq_o)
    else $error("timer did not reload on overflow");

  AST_COUNT_UP: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && tick && !wrap
    |=> tmr_o.cnt == $past(tmr_o.cnt) + 16'h0001)
    else $error("timer did not step by one");

  AST_HOLD_NO_TICK: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i && !tick |=> $stable(tmr_o.cnt) && !tmr_o.upd)
    else $error("timer moved without a tick");

  AST_PRESCALE_RANGE: assert property (@(posedge clk_i)
    disable iff (rst_i) pre_r <= pre_term || !cfg_i.run
      || $changed(cfg_i.tis) || $past(cfg_i.tis) != cfg_i.tis)
    else $error("prescaler ran past its divider");

endmodule : ccu_timebase

// ==== hdl/ccu_top.sv ====
// dual capture/compare array: two units, two time bases and 16 channels each
`timescale 1ns/1ps
module ccu_top #(
  parameter int N_UNIT = ccu_pkg::N_UNIT,
  parameter int N_CH = ccu_pkg::N_CH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // timer configuration, index 0 is the first time base
  input wire ccu_pkg::ccu_tmr_cfg_type tmr_cfg_i [N_UNIT][2],
  input wire logic ext_cnt_i [N_UNIT],
  input wire logic gpt_ovf_i,
  // channel configuration
  input wire ccu_pkg::ccu_chan_cfg_type chan_cfg_i [N_UNIT][N_CH],
  input wire logic [N_CH/2-1:0] dbl_i [N_UNIT],
  // register write
  input wire logic wr_en_i,
  input wire logic [$clog2(N_UNIT)-1:0] wr_unit_i,
  input wire logic [$clog2(N_CH)-1:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  // register read
  input wire logic [$clog2(N_UNIT)-1:0] rd_unit_i,
  input wire logic [$clog2(N_CH)-1:0] rd_idx_i,
  output logic [15:0] rd_data_o,
  // channel pins
  input wire logic [N_CH-1:0] ch_pin_i [N_UNIT],
  output logic [N_CH-1:0] ch_pin_o [N_UNIT],
  output logic [N_CH-1:0] ch_pin_oe_o [N_UNIT],
  // requests and timer state
  output logic [N_CH-1:0] ch_irq_o [N_UNIT],
  output logic [1:0] tmr_irq_o [N_UNIT],
  output logic [15:0] tmr_cnt_o [N_UNIT][2]
);

  ccu_pkg::ccu_tmr_type tmr_w [N_UNIT][2];
  logic [15:0] val_w [N_UNIT][N_CH];
  logic [N_CH-1:0] match_w [N_UNIT];

  // double mode pairs channel i with i + N_CH/2
  if (N_UNIT < 1 || N_CH < 2 || N_CH % 2 != 0
      || N_UNIT != ccu_pkg::N_UNIT) begin : g_bad
    $error("ccu_top: unsupported unit or channel count");
  end

  for (genvar u = 0; u < N_UNIT; u++) begin : g_unit
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      // only the first time base has a count pin
      ccu_timebase #(
        .HAS_EXT(t == 0)
      ) u_tb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .cfg_i(tmr_cfg_i[u][t]),
        .ext_pin_i(ext_cnt_i[u]),
        .gpt_ovf_i(gpt_ovf_i),
        .tmr_o(tmr_w[u][t]),
        .irq_o(tmr_irq_o[u][t])
      );
      assign tmr_cnt_o[u][t] = tmr_w[u][t].cnt;

      sequence s_two_ticks;
        ce_i && tmr_w[u][t].upd ##1 ce_i && tmr_w[u][t].upd;
      endsequence

      AST_COUNT_OUT: assert property (@(posedge clk_i)
        disable iff (rst_i) s_two_ticks
        |-> tmr_cnt_o[u][t] == $past(tmr_cnt_o[u][t]) + 16'h0001
          || tmr_w[u][t].ovf)
        else $error("timer output skipped a count");
    end

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
      logic lead;
      logic follow;
      logic partner;
      logic wr_hit;

      if (c < N_CH / 2) begin : g_low
        assign lead = dbl_i[u][c];
        assign follow = 1'b0;
        assign partner = match_w[u][c + N_CH / 2];
      end else begin : g_high
        assign lead = 1'b0;
        assign follow = dbl_i[u][c - N_CH / 2];
        assign partner = 1'b0;
      end

      assign wr_hit = wr_en_i && wr_unit_i == u && wr_idx_i == c;

      ccu_channel u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .cfg_i(chan_cfg_i[u][c]),
        .dbl_lead_i(lead),
        .dbl_follow_i(follow),
        .partner_match_i(partner),
        .tmr_i(chan_cfg_i[u][c].alloc ? tmr_w[u][1] : tmr_w[u][0]),
        .wr_en_i(wr_hit),
        .wr_data_i(wr_data_i),
        .pin_i(ch_pin_i[u][c]),
        .pin_o(ch_pin_o[u][c]),
        .pin_oe_o(ch_pin_oe_o[u][c]),
        .val_o(val_w[u][c]),
        .irq_o(ch_irq_o[u][c]),
        .match_o(match_w[u][c])
      );

      sequence s_mode0_match;
        ce_i && match_w[u][c]
          && chan_cfg_i[u][c].mode == ccu_pkg::CCU_CMP0;
      endsequence

      AST_MODE0_IRQ: assert property (@(posedge clk_i)
        disable iff (rst_i) s_mode0_match |=> ch_irq_o[u][c])
        else $error("mode 0 match without request");

      AST_MODE0_PIN: assert property (@(posedge clk_i)
        disable iff (rst_i) (s_mode0_match and !lead && !follow)
        |=> $stable(ch_pin_o[u][c]))
        else $error("mode 0 match moved the pin");

      // only channels below N_CH/2 see a partner, so followers pass vacuously
      AST_DOUBLE_TOGGLE: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && lead && partner && !match_w[u][c]
        |=> ch_pin_o[u][c] != $past(ch_pin_o[u][c]))
        else $error("partner match did not toggle shared pin");

      AST_DOUBLE_FOLLOW_OFF: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && follow |=> !ch_pin_oe_o[u][c])
        else $error("follower channel drives its pin");
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= ccu_pkg::TMR_RST;
    end else if (ce_i) begin
      rd_data_o <= val_w[rd_unit_i][rd_idx_i];
    end
  end

  AST_READ_BACK: assert property (@(posedge clk_i)
    disable iff (rst_i) ce_i
    |=> rd_data_o == $past(val_w[rd_unit_i][rd_idx_i]))
    else $error("read port does not follow selected register");

endmodule : ccu_top

// ==== dv/ccu_pin_model.sv ====
// outside world of the channel pins: drives undriven pins from a level
`timescale 1ns/1ps
module ccu_pin_model (
  // device side
  input wire logic [15:0] pin_o_i,
  input wire logic [15:0] pin_oe_i,
  // commanded outside level
  input wire logic [15:0] lvl_i,
  output logic [15:0] pin_i_o
);
  // a driven pin reads back its own drive, never the stale outside level
  always_comb pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & lvl_i);
endmodule : ccu_pin_model

// ==== dv/dual_capture_compare_array_tb.sv ====
// self-checking bench of the dual capture/compare array
`timescale 1ns/1ps
module dual_capture_compare_array_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  ccu_pkg::ccu_tmr_cfg_type tc [2][2];
  logic ext [2];
  logic gpt = 1'b0;
  ccu_pkg::ccu_chan_cfg_type cc [2][16];
  logic [7:0] dbl [2];
  logic wr_en = 1'b0;
  logic wr_u = 1'b0;
  logic [3:0] wr_idx = 4'h0;
  logic [15:0] wr_d = 16'h0000;
  logic rd_u = 1'b0;
  logic [3:0] rd_idx = 4'h0;
  logic [15:0] rd_d;
  logic [15:0] lvl [2];
  logic [15:0] pin_in [2];
  logic [15:0] pin_o [2];
  logic [15:0] pin_oe [2];
  logic [15:0] irq [2];
  logic [1:0] tirq [2];
  logic [15:0] cnt [2][2];
  logic [3:0] icnt [4];
  logic [3:0] ccnt;
  logic [3:0] tcnt;
  logic [15:0] tv;
  int mismatches = 0;
  int comparisons = 0;

  initial forever #25 clk_i = ~clk_i;

  ccu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .tmr_cfg_i(tc),
    .ext_cnt_i(ext), .gpt_ovf_i(gpt), .chan_cfg_i(cc), .dbl_i(dbl),
    .wr_en_i(wr_en), .wr_unit_i(wr_u), .wr_idx_i(wr_idx), .wr_data_i(wr_d),
    .rd_unit_i(rd_u), .rd_idx_i(rd_idx), .rd_data_o(rd_d),
    .ch_pin_i(pin_in), .ch_pin_o(pin_o), .ch_pin_oe_o(pin_oe),
    .ch_irq_o(irq), .tmr_irq_o(tirq), .tmr_cnt_o(cnt));

  ccu_pin_model i_pins0 (.pin_o_i(pin_o[0]), .pin_oe_i(pin_oe[0]),
    .lvl_i(lvl[0]), .pin_i_o(pin_in[0]));
  ccu_pin_model i_pins1 (.pin_o_i(pin_o[1]), .pin_oe_i(pin_oe[1]),
    .lvl_i(lvl[1]), .pin_i_o(pin_in[1]));

  // request pulses last one cycle, so count them as they pass
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (irq[1][k] === 1'b1) icnt[k] <= icnt[k] + 4'h1;
    end
    if (irq[0][0] === 1'b1) ccnt <= ccnt + 4'h1;
    if (tirq[1][0] === 1'b1) tcnt <= tcnt + 4'h1;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i) #1;
  endtask : cyc

  task automatic wr(input logic u, input logic [3:0] i, input logic [15:0] d);
    wr_en = 1'b1;
    wr_u = u;
    wr_idx = i;
    wr_d = d;
    cyc(1);
    wr_en = 1'b0;
    // an idle edge keeps back-to-back writes from re-raising in one step
    cyc(1);
  endtask : wr

  // one gpt overflow tick, then let count, compare and pin settle
  task automatic tick(input int n);
    repeat (n) begin
      gpt = 1'b1;
      cyc(1);
      gpt = 1'b0;
      cyc(3);
    end
  endtask : tick

  task automatic cmp_state(input logic [15:0] e_irq, input logic [4:0] e_pin);
    check({icnt[3], icnt[2], icnt[1], icnt[0]}, e_irq);
    check({11'h000, pin_o[1][4:0]}, {11'h000, e_pin});
  endtask : cmp_state

  initial begin
    #4_500_000;
    mismatches++;
    close_out();
  end

  initial begin
    for (int u = 0; u < 2; u++) begin
      tc[u][0] = '{1'b1, ccu_pkg::CCU_SRC_GPT_OVF, 3'h0, 16'hFFF0};
      tc[u][1] = '{1'b0, ccu_pkg::CCU_SRC_PRESCALE, 3'h0, 16'h0000};
      for (int k = 0; k < 16; k++) cc[u][k] = '{ccu_pkg::CCU_OFF,
        ccu_pkg::CCU_EDGE_RISE, 1'b0};
      dbl[u] = 8'h00;
      ext[u] = 1'b0;
      lvl[u] = 16'h0000;
    end
    cc[1][0].mode = ccu_pkg::CCU_CMP0;
    cc[1][1].mode = ccu_pkg::CCU_CMP1;
    cc[1][2].mode = ccu_pkg::CCU_CMP2;
    cc[1][3].mode = ccu_pkg::CCU_CMP3;
    cc[1][4].mode = ccu_pkg::CCU_CMP1;
    cc[1][12].mode = ccu_pkg::CCU_CMP1;
    dbl[1] = 8'h10;
    cyc(8);
    rst_i = 1'b0;
    check(cnt[1][0], 16'h0000);
    for (int k = 0; k < 4; k++) wr(1'b1, k[3:0], 16'hFFF4);
    wr(1'b1, 4'h4, 16'hFFF2);
    wr(1'b1, 4'hC, 16'hFFF6);
    tcnt = 4'h0;
    // first period from reset value 0000h is the full 65536 ticks
    gpt = 1'b1;
    cyc(65536);
    gpt = 1'b0;
    cyc(4);
    check(cnt[1][0], 16'hFFF0);
    check({12'h000, tcnt}, 16'h0001);
    check({11'h000, pin_o[1][4:0]}, 16'h0002);
    check({15'h0000, pin_oe[1][12]}, 16'h0000);
    icnt = '{default: 4'h0};
    tick(4);
    cmp_state(16'h1111, 5'h18);
    for (int k = 0; k < 4; k++) wr(1'b1, k[3:0], 16'hFFF6);
    rd_u = 1'b1;
    cyc(2);
    check(rd_d, 16'hFFF6);
    tick(2);
    cmp_state(16'h1122, 5'h0A);
    // a match in the overflow cycle opens the new period for mode 2
    wr(1'b1, 4'h2, 16'hFFF0);
    tick(10);
    cmp_state(16'h1222, 5'h02);
    check({12'h000, tcnt}, 16'h0002);
    tick(6);
    cmp_state(16'h2233, 5'h08);
    // capture on unit a, register 0, first timer
    tv = 16'hFFF6;
    rd_u = 1'b0;
    for (int e = 0; e < 3; e++) begin
      cc[0][0] = '{ccu_pkg::CCU_CAPTURE, ccu_pkg::ccu_edge_type'(e), 1'b0};
      tick(1);
      tv = tv + 16'h0001;
      ccnt = 4'h0;
      lvl[0][0] = 1'b1;
      cyc(6);
      lvl[0][0] = 1'b0;
      cyc(6);
      check({12'h000, ccnt}, (e == 2) ? 16'h0002 : 16'h0001);
      check(rd_d, tv);
    end
    // second timer is still stopped at 0000h
    cc[0][0].alloc = 1'b1;
    lvl[0][0] = 1'b1;
    cyc(6);
    lvl[0][0] = 1'b0;
    cyc(6);
    check(rd_d, 16'h0000);
    // first count pulse falls while frozen and must be lost
    tc[0][0].src = ccu_pkg::CCU_SRC_EXT_PIN;
    ce = 1'b0;
    for (int f = 0; f < 2; f++) begin
      cyc(2);
      ext[0] = 1'b1;
      cyc(6);
      ext[0] = 1'b0;
      cyc(4);
      ce = 1'b1;
    end
    cyc(2);
    check(cnt[0][0], tv + 16'h0001);
    // prescaled second timer: interval between two counts
    tc[0][1].run = 1'b1;
    for (int t = 0; t < 8; t++) begin
      int n;
      tc[0][1].tis = t[2:0];
      for (int w = 0; w < 2; w++) begin
        tv = cnt[0][1];
        n = 0;
        while (cnt[0][1] === tv && n < 2100) begin
          cyc(1);
          n++;
        end
      end
      check(n[15:0], 16'h0008 << t);
    end
    close_out();
  end
endmodule : dual_capture_compare_array_tb
